// *** include/ssio_pkg.sv ***
`default_nettype none
package ssio_pkg;
  // Register indices; byte address is four times the index
  localparam logic [31:0] CTL_TWO_IDX   = 32'hfffff250;
  localparam logic [31:0] DATA_BUF_IDX  = 32'hfffff252;
  localparam logic [31:0] CTL_ONE_IDX   = 32'hfffff253;
  localparam logic [31:0] UNIT_EN_IDX   = 32'hfffff254;
  localparam logic [31:0] BAUD_ZERO_IDX = 32'hfffff257;
  localparam logic [31:0] IRQ_STAT_IDX  = 32'hfffff258;
  localparam logic [31:0] IRQ_MASK_IDX  = 32'hfffff259;
  // Field positions
  localparam int UNIT_EN_BIT  = 7;
  localparam int START_BIT    = 7;
  localparam int ABORT_BIT    = 6;
  localparam int MODE_LSB     = 4;
  localparam int SCK_LSB      = 0;
  localparam int OPM_LSB      = 2;
  localparam int XFER_BIT     = 3;
  localparam int SHIFT_BIT    = 2;
  localparam int IDLE_RUN_BIT = 6;
  localparam int IRQ_BUF      = 0;
  localparam int IRQ_END      = 1;
  // Values after reset
  localparam logic [2:0] SCK_RST  = 3'h1;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [1:0] OPM_RST  = 2'h0;
  // Codes
  localparam logic [1:0] MODE_TX   = 2'h0;
  localparam logic [1:0] MODE_TXRX = 2'h2;
  localparam logic [1:0] MODE_RX   = 2'h3;
  localparam logic [1:0] OPM_SIO   = 2'h1;
  localparam logic [2:0] SCK_EXT   = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Half serial period is 2^(code+4) cycles: fsys/4/2^(code+3)
  localparam logic [3:0] SCK_HALF_LOG2_OFS = 4'h4;
  localparam logic [2:0] LAST_BIT = 3'h7;
  typedef enum logic [2:0] {
    ENG_IDLE  = 3'b001,
    ENG_SHIFT = 3'b010,
    ENG_WAIT  = 3'b100
  } ssio_eng_st_t;
endpackage
`default_nettype wire

// *** rtl/ssio_engine.sv ***
`timescale 1ns/1ns
`default_nettype none
module ssio_engine import ssio_pkg::*; (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [1:0] mode,
  input  wire logic [2:0] sck_sel,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       rx_ready,
  input  wire logic       sclk_pin,
  input  wire logic       si_pin,
  output logic            tx_take,
  output logic            rx_put,
  output logic [7:0]      rx_data,
  output logic            sclk_out,
  output logic            sclk_oe,
  output logic            so,
  output logic            xfer_active,
  output logic            shift_active
);
  typedef struct packed {
    ssio_eng_st_t st;
    logic [10:0]  cnt;
    logic [2:0]   bits;
    logic [7:0]   sh;
    logic         sck;
    logic         so;
    logic         pend_rx;
    logic [2:0]   sc;
    logic [1:0]   sd;
    logic         take;
    logic         put;
  } ssio_eng_t;
  localparam ssio_eng_t ENG_RST = '{st: ENG_IDLE, sck: 1'b1, default: '0};
  ssio_eng_t q, n;
  logic ext, tx_m, rx_m, tick, fall, rise;
  logic [10:0] half;

  // Next state; abort and loss of run override the state, the clock level and the pending receive
  always_comb
  begin
    n = q;
    n.take = 1'b0;
    n.put = 1'b0;
    n.sc = {q.sc[1:0], sclk_pin};
    n.sd = {q.sd[0], si_pin};
    ext = (sck_sel == SCK_EXT);
    tx_m = (mode == MODE_TX) || (mode == MODE_TXRX);
    rx_m = (mode == MODE_RX) || (mode == MODE_TXRX);
    half = 11'h1 << (4'(sck_sel) + SCK_HALF_LOG2_OFS);
    tick = !ext && (q.cnt == half - 11'h1);
    fall = ext ? (!q.sc[1] && q.sc[2]) : (tick && q.sck);
    rise = ext ? (q.sc[1] && !q.sc[2]) : (tick && !q.sck);
    case (q.st)
      ENG_IDLE:
      begin
        n.sck = 1'b1;
        n.cnt = '0;
        n.pend_rx = 1'b0;
        if (start && (tx_m || rx_m))
          n.st = ENG_WAIT;
      end
      ENG_WAIT:
      begin
        // Clock parked high until the buffer side catches up
        n.sck = 1'b1;
        n.cnt = '0;
        if (q.pend_rx)
        begin
          if (rx_ready)
          begin
            n.put = 1'b1;
            n.pend_rx = 1'b0;
          end
        end
        else if (!start)
          n.st = ENG_IDLE;
        else if (!tx_m || tx_valid)
        begin
          n.take = tx_m;
          n.sh = tx_m ? tx_data : q.sh;
          n.bits = '0;
          n.st = ENG_SHIFT;
        end
      end
      ENG_SHIFT:
      begin
        n.cnt = tick ? '0 : q.cnt + 11'h1;
        if (tick)
          n.sck = !q.sck;
        // Falling edge drives, rising edge samples, LSB first
        if (fall)
          n.so = q.sh[0];
        if (rise)
        begin
          n.sh = {q.sd[1], q.sh[7:1]};
          n.bits = q.bits + 3'h1;
          if (q.bits == LAST_BIT)
          begin
            n.pend_rx = rx_m;
            n.st = ENG_WAIT;
          end
        end
      end
      default: n.st = ENG_IDLE;
    endcase
    if (!run || abort)
    begin
      n.st = ENG_IDLE;
      n.sck = 1'b1;
      n.pend_rx = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      q <= ENG_RST;
    else
      q <= n;
  end

  assign tx_take = q.take;
  assign rx_put = q.put;
  assign rx_data = q.sh;
  assign sclk_out = q.sck;
  assign sclk_oe = run && !ext;
  assign so = q.so;
  assign xfer_active = (q.st != ENG_IDLE);
  assign shift_active = (q.st == ENG_SHIFT);

  a_abort_stops: assert property (@(posedge clock) disable iff (!rst_n)
    abort |=> !xfer_active && !shift_active) else $error("abort did not stop transfer");
  a_ext_no_drive: assert property (@(posedge clock) disable iff (!rst_n)
    (sck_sel == SCK_EXT) |-> !sclk_oe) else $error("clock pin driven in external mode");
  a_div_bound: assert property (@(posedge clock) disable iff (!rst_n)
    (!ext && q.st == ENG_SHIFT) |-> q.cnt < half) else $error("divider overran half period");
  a_rsv_mode: assert property (@(posedge clock) disable iff (!rst_n)
    (q.st == ENG_IDLE && mode == 2'h1) |=> !xfer_active) else $error("reserved mode started");
  c_byte_done: cover property (@(posedge clock) disable iff (!rst_n) q.st == ENG_SHIFT ##1 q.st == ENG_WAIT);
  c_abort_mid: cover property (@(posedge clock) disable iff (!rst_n) shift_active && abort);
endmodule
`default_nettype wire

// *** rtl/ssio_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module ssio_top import ssio_pkg::*; (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        idle_standby,
  input  wire logic        sclk_pin_in,
  output logic             sclk_pin_out,
  output logic             sclk_pin_oe,
  output logic             so_pin,
  input  wire logic        si_pin,
  output logic             irq
);
  typedef struct packed {
    logic       en;
    logic       start;
    logic       abort;
    logic [1:0] mode;
    logic [2:0] sck;
    logic [1:0] opm;
    logic       idle_run;
    logic [7:0] txbuf;
    logic       tx_full;
    logic [7:0] rxbuf;
    logic       rx_full;
    logic [1:0] ist;
    logic [1:0] imask;
    logic       xfer_prev;
    logic       aw_have;
    logic [9:0] aw_idx;
    logic       w_have;
    logic [7:0] wdata;
    logic       wstb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } ssio_regs_t;
  localparam ssio_regs_t REG_RST = '{sck: SCK_RST, mode: MODE_RST, opm: OPM_RST, default: '0};
  ssio_regs_t q, n;
  logic       run, eng_take, eng_put, xfer_active, shift_active, xfer_end, do_write, rd_take;
  logic [7:0] eng_rx, d;
  logic [9:0] rd_idx;

  // Engine is alive only when enabled, in serial mode and not parked by idle standby
  assign run = q.en && (q.opm == OPM_SIO) && (q.idle_run || !idle_standby);

  ssio_engine u_engine (
    .clock        (clock),
    .rst_n        (rst_n),
    .run          (run),
    .start        (q.start),
    .abort        (q.abort),
    .mode         (q.mode),
    .sck_sel      (q.sck),
    .tx_data      (q.txbuf),
    .tx_valid     (q.tx_full),
    .rx_ready     (!q.rx_full),
    .sclk_pin     (sclk_pin_in),
    .si_pin       (si_pin),
    .tx_take      (eng_take),
    .rx_put       (eng_put),
    .rx_data      (eng_rx),
    .sclk_out     (sclk_pin_out),
    .sclk_oe      (sclk_pin_oe),
    .so           (so_pin),
    .xfer_active  (xfer_active),
    .shift_active (shift_active)
  );

  // Handshake outputs from flops only; one write and one read in flight
  assign s_axi_awready = !q.aw_have && !q.bvalid;
  assign s_axi_wready = !q.w_have && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = {24'h0, q.rdata};
  assign irq = |(q.ist & q.imask);

  assign xfer_end = q.xfer_prev && !xfer_active;
  assign do_write = q.aw_have && q.w_have && !q.bvalid;
  assign rd_take = s_axi_arvalid && !q.rvalid;
  assign rd_idx = s_axi_araddr[11:2];
  assign d = q.wdata;

  // All register and bus state advances here; clears first, hardware sets last
  always_comb
  begin
    n = q;
    n.xfer_prev = xfer_active;
    // Engine has copied the buffer into its shifter
    if (eng_take)
      n.tx_full = 1'b0;
    // Capture address and data in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      n.aw_have = 1'b1;
      n.aw_idx = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      n.w_have = 1'b1;
      n.wdata = s_axi_wdata[7:0];
      n.wstb = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready)
      n.bvalid = 1'b0;
    // Register write; disabled unit ignores all but the enable register
    if (do_write)
    begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (q.aw_idx)
        UNIT_EN_IDX[9:0]:
          if (q.wstb)
            n.en = d[UNIT_EN_BIT];
        CTL_ONE_IDX[9:0]:
          if (q.wstb && q.en)
          begin
            n.start = d[START_BIT];
            n.abort = d[ABORT_BIT];
            n.mode = d[MODE_LSB +: 2];
            n.sck = d[SCK_LSB +: 3];
          end
        DATA_BUF_IDX[9:0]:
          if (q.wstb && q.en)
          begin
            // A write in the take cycle keeps the new byte pending
            n.txbuf = d;
            n.tx_full = 1'b1;
          end
        CTL_TWO_IDX[9:0]:
          if (q.wstb && q.en)
            n.opm = d[OPM_LSB +: 2];
        BAUD_ZERO_IDX[9:0]:
          if (q.wstb && q.en)
            n.idle_run = d[IDLE_RUN_BIT];
        IRQ_MASK_IDX[9:0]:
          if (q.wstb && q.en)
            n.imask = d[1:0];
        IRQ_STAT_IDX[9:0]:
          if (q.wstb && q.en)
            n.ist = q.ist & ~d[1:0];
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    if (q.rvalid && s_axi_rready)
      n.rvalid = 1'b0;
    // Register read; disabled unit reads 0 except the enable register
    if (rd_take)
    begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 8'h00;
      case (rd_idx)
        UNIT_EN_IDX[9:0]:
          n.rdata[UNIT_EN_BIT] = q.en;
        CTL_ONE_IDX[9:0]:
          if (q.en)
          begin
            n.rdata[START_BIT] = q.start;
            n.rdata[ABORT_BIT] = q.abort;
            n.rdata[MODE_LSB +: 2] = q.mode;
            n.rdata[SCK_LSB +: 3] = q.sck;
          end
        DATA_BUF_IDX[9:0]:
          if (q.en)
          begin
            // Reading frees the buffer so a stalled receive can move on
            n.rdata = q.rxbuf;
            n.rx_full = 1'b0;
          end
        CTL_TWO_IDX[9:0]:
          if (q.en)
          begin
            n.rdata[XFER_BIT] = xfer_active;
            n.rdata[SHIFT_BIT] = shift_active;
          end
        BAUD_ZERO_IDX[9:0]:
          if (q.en)
            n.rdata[IDLE_RUN_BIT] = q.idle_run;
        IRQ_MASK_IDX[9:0]:
          if (q.en)
            n.rdata[1:0] = q.imask;
        IRQ_STAT_IDX[9:0]:
          if (q.en)
            n.rdata[1:0] = q.ist;
        default: n.rresp = RESP_SLVERR;
      endcase
    end
    // Hardware sets come last so they win over a same-cycle clear
    if (eng_put)
    begin
      n.rxbuf = eng_rx;
      n.rx_full = 1'b1;
    end
    if (eng_take || eng_put)
      n.ist[IRQ_BUF] = 1'b1;
    if (xfer_end)
      n.ist[IRQ_END] = 1'b1;
  end

  // Single state register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      q <= REG_RST;
    else
      q <= n;
  end

  a_en_gates_write: assert property (@(posedge clock) disable iff (!rst_n)
    (!q.en && do_write && q.aw_idx == CTL_ONE_IDX[9:0])
    |=> $stable(q.mode) && $stable(q.sck) && $stable(q.start))
    else $error("control written while unit disabled");
  a_en_read_low: assert property (@(posedge clock) disable iff (!rst_n)
    (rd_take && rd_idx == UNIT_EN_IDX[9:0])
    |=> s_axi_rvalid && s_axi_rdata[6:0] == 7'h00 && s_axi_rdata[7] == $past(q.en))
    else $error("enable register read wrong");
  a_cfg_kept: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(q.en) |-> $stable(q.sck) && $stable(q.mode) && $stable(q.opm) && $stable(q.idle_run))
    else $error("settings lost on disable");
  a_status_read: assert property (@(posedge clock) disable iff (!rst_n)
    (q.en && rd_take && rd_idx == CTL_TWO_IDX[9:0])
    |=> s_axi_rdata[XFER_BIT] == $past(xfer_active) && s_axi_rdata[SHIFT_BIT] == $past(shift_active))
    else $error("status read does not show flags");
  a_rx_capture: assert property (@(posedge clock) disable iff (!rst_n)
    eng_put |=> q.rx_full && q.rxbuf == $past(eng_rx) && q.ist[IRQ_BUF])
    else $error("received byte not latched");
  a_opm_gate: assert property (@(posedge clock) disable iff (!rst_n)
    (q.opm != OPM_SIO) |=> !xfer_active)
    else $error("engine ran outside serial mode");
  a_idle_stops: assert property (@(posedge clock) disable iff (!rst_n)
    (!q.idle_run && idle_standby) |=> !xfer_active)
    else $error("unit kept running in idle standby");
  a_end_sets_irq: assert property (@(posedge clock) disable iff (!rst_n)
    (xfer_end ##0 q.imask[IRQ_END]) |=> irq)
    else $error("transfer end not flagged");
  a_write_resp: assert property (@(posedge clock) disable iff (!rst_n)
    do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write not answered");
  c_tx_take: cover property (@(posedge clock) disable iff (!rst_n) eng_take);
  c_rx_put: cover property (@(posedge clock) disable iff (!rst_n) eng_put ##[1:200] rd_take);
  c_irq: cover property (@(posedge clock) disable iff (!rst_n) $rose(irq));
endmodule
`default_nettype wire

// *** testbench/ssio_peer.sv ***
`timescale 1ns/1ns
`default_nettype none
// Serial peer: reads the data-out line and feeds the data-in line, LSB first
module ssio_peer (
  input  wire logic sck,
  input  wire logic so,
  output logic      si,
  output logic      ext_clk
);
  logic [7:0] out_b  = 8'h00;
  logic [7:0] got    = 8'h00;
  int         nbits  = 0;
  time        t_fall = 0;
  time        half   = 0;
  initial
  begin
    si = 1'b0;
    ext_clk = 1'b1;
  end
  task automatic load(input logic [7:0] b);
    out_b = b;
    nbits = 0;
  endtask
  // The external clock runs only inside a frame and rests high between frames
  task automatic ext_run(input int n);
    repeat (n)
    begin
      #80 ext_clk = 1'b0;
      #80 ext_clk = 1'b1;
    end
  endtask
  // Next bit goes out right after the falling edge
  always @(negedge sck)
  begin
    t_fall = $time;
    si = out_b[nbits[2:0]];
  end
  // Sample 40 ns into the high phase, clear of the data change after a detected edge
  always @(posedge sck)
  begin
    half = $time - t_fall;
    #40 got = {so, got[7:1]};
    nbits = nbits + 1;
    if (nbits == 8)
      si = ~si; // A released line shows the inverse, never a held value
  end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top import ssio_pkg::*; ;
  logic        clock, rst_n, idle_standby, sclk_pin_out, sclk_pin_oe, so_pin, si_pin, irq, ext_clk;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, last_data, rnd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp, md;
  logic [2:0]  ck;
  logic [7:0]  msk;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          num_errors, checks_done;
  wire logic   sck_line;
  // The clock pin carries whichever party has it enabled
  assign sck_line = sclk_pin_oe ? sclk_pin_out : ext_clk;
  ssio_top dut_u (
    .clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .idle_standby(idle_standby),
    .sclk_pin_in(sck_line), .sclk_pin_out(sclk_pin_out), .sclk_pin_oe(sclk_pin_oe),
    .so_pin(so_pin), .si_pin(si_pin), .irq(irq)
  );
  ssio_peer peer_u (.sck(sck_line), .so(so_pin), .si(si_pin), .ext_clk(ext_clk));
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic complete_run();
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic fail_wait();
    num_errors++;
    complete_run();
  endtask
  // Register value, serial byte or pin against the model
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp({30'h0, got}, {30'h0, exp});
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Address and data offered together; each released on its own handshake
  task automatic wr(input logic [31:0] idx, input logic [7:0] d);
    int   n;
    logic a, w, done;
    n = 0;
    done = 1'b0;
    s_axi_awaddr  <= {idx[9:0], 2'b00};
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done && n < 100)
    begin
      @(negedge clock);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      last_resp = s_axi_bresp;
      @(posedge clock);
      if (a)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
      if (done)
        s_axi_bready <= 1'b0;
      n++;
    end
    if (!done)
      fail_wait();
    @(posedge clock);
  endtask
  task automatic rd(input logic [31:0] idx);
    int   n;
    logic a, done;
    n = 0;
    done = 1'b0;
    s_axi_araddr  <= {idx[9:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done && n < 100)
    begin
      @(negedge clock);
      a = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      last_data = s_axi_rdata;
      last_resp = s_axi_rresp;
      @(posedge clock);
      if (a)
        s_axi_arvalid <= 1'b0;
      if (done)
        s_axi_rready <= 1'b0;
      n++;
    end
    if (!done)
      fail_wait();
    @(posedge clock);
  endtask
  task automatic rd_chk(input logic [31:0] idx, input logic [7:0] exp);
    rd(idx);
    cmp(last_data, {24'h000000, exp});
    cmp_resp(last_resp, RESP_OKAY);
  endtask
  // Abort first so mode and clock may change, then load and start
  task automatic setup(input logic [1:0] m, input logic [2:0] c, input logic [7:0] tb_b, input logic [7:0] pb);
    wr(CTL_ONE_IDX, {2'b01, m, 1'b0, c});
    peer_u.load(pb);
    if (m != MODE_RX)
      wr(DATA_BUF_IDX, tb_b);
    wr(CTL_ONE_IDX, {2'b10, m, 1'b0, c});
  endtask
  // Clearing start lets the current byte complete, then the flags drop
  task automatic finish(input logic [1:0] m, input logic [2:0] c, input logic [7:0] tb_b, input logic [7:0] pb);
    int n;
    n = 0;
    wr(CTL_ONE_IDX, {2'b00, m, 1'b0, c});
    cmp(sclk_pin_oe, c != SCK_EXT);
    if (c == SCK_EXT)
    begin
      peer_u.ext_run(8);
      @(posedge clock);
    end
    last_data = 32'h00000008;
    while (last_data[XFER_BIT] && n < 9000)
    begin
      rd(CTL_TWO_IDX);
      n++;
    end
    if (last_data[XFER_BIT])
      fail_wait();
    cmp(last_data, 32'h00000000);
    if (m != MODE_RX)
      cmp(peer_u.got, tb_b);
    if (m != MODE_TX)
      rd_chk(DATA_BUF_IDX, pb);
    if (c != SCK_EXT)
      cmp(peer_u.half[31:0], 32'h00000014 << (c + 4));
    cmp(irq, msk != 8'h00);
    rd_chk(IRQ_STAT_IDX, 8'h03);
    wr(IRQ_STAT_IDX, 8'h03);
    cmp(irq, 1'b0);
  endtask
  // Main sequence
  initial
  begin
    num_errors = 0;
    checks_done = 0;
    rnd = 32'h0000e687;
    msk = 8'h00;
    rst_n = 1'b0;
    idle_standby = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h1;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd_chk(UNIT_EN_IDX, 8'h00);
    wr(CTL_ONE_IDX, 8'h41);
    rd_chk(CTL_ONE_IDX, 8'h00);
    wr(UNIT_EN_IDX, 8'hff);
    rd_chk(UNIT_EN_IDX, 8'h80);
    rd_chk(CTL_ONE_IDX, {5'h00, SCK_RST});
    rd_chk(CTL_TWO_IDX, 8'h00);
    rd_chk(BAUD_ZERO_IDX, 8'h00);
    wr(BAUD_ZERO_IDX, 8'hfe);
    rd_chk(BAUD_ZERO_IDX, 8'h40);
    wr(BAUD_ZERO_IDX, 8'h00);
    wr(CTL_ONE_IDX, 8'h46);
    wr(UNIT_EN_IDX, 8'h00);
    rd_chk(CTL_ONE_IDX, 8'h00);
    wr(UNIT_EN_IDX, 8'h80);
    rd_chk(CTL_ONE_IDX, 8'h46);
    wr(32'h00000255, 8'h5a);
    cmp_resp(last_resp, RESP_SLVERR);
    rd(32'h00000255);
    cmp(last_data, 32'h00000000);
    cmp_resp(last_resp, RESP_SLVERR);
    rnd = xs(rnd);
    wr(CTL_TWO_IDX, 8'h00);
    setup(MODE_TX, 3'h0, rnd[7:0], 8'h00);
    rd_chk(CTL_TWO_IDX, 8'h00);
    wr(CTL_TWO_IDX, 8'h04);
    setup(2'h1, 3'h0, rnd[7:0], 8'h00);
    rd_chk(CTL_TWO_IDX, 8'h00);
    idle_standby <= 1'b1;
    setup(MODE_TX, 3'h0, rnd[7:0], 8'h00);
    rd_chk(CTL_TWO_IDX, 8'h00);
    wr(BAUD_ZERO_IDX, 8'h40);
    finish(MODE_TX, 3'h0, rnd[7:0], 8'h00);
    msk = 8'h02;
    wr(IRQ_MASK_IDX, msk);
    // Every internal clock code, each with a fresh byte
    for (int c = 0; c < 7; c++)
    begin
      rnd = xs(rnd);
      setup(MODE_TX, c[2:0], rnd[7:0], 8'h00);
      rd_chk(CTL_TWO_IDX, 8'h0c);
      finish(MODE_TX, c[2:0], rnd[7:0], 8'h00);
    end
    // Both-way and receive modes, internal then external clock
    for (int i = 0; i < 4; i++)
    begin
      rnd = xs(rnd);
      md = i[0] ? MODE_RX : MODE_TXRX;
      ck = i[1] ? SCK_EXT : 3'h1;
      setup(md, ck, rnd[7:0], rnd[15:8]);
      finish(md, ck, rnd[7:0], rnd[15:8]);
    end
    rnd = xs(rnd);
    setup(MODE_TX, 3'h6, rnd[7:0], 8'h00);
    rd_chk(CTL_TWO_IDX, 8'h0c);
    wr(CTL_ONE_IDX, 8'h46);
    rd_chk(CTL_TWO_IDX, 8'h00);
    wr(IRQ_STAT_IDX, 8'h03);
    cmp(irq, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
